/* File: design/sow_config.sv */
// System option registers, pin function control and watchdog
`timescale 1ns/10ps
module sow_config #(
  parameter int unsigned LPO_DIV = sow_pkg::LPO_DIV_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       sys_reset_in,
  input  wire logic       reset_pin_n_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_strobe_in,
  input  wire logic       rd_strobe_in,
  output logic      [7:0] rd_data_out,
  output logic            debug_pin_enable_out,
  output logic            reset_pin_enable_out,
  output logic            reset_pullup_enable_out,
  output logic            spi_filter_enable_out,
  output logic            flash_protection_disable_out,
  output logic            system_reset_out
);
  logic [1:0]       watchdog_timeout_select;
  logic             debug_pin_enable;
  logic             reset_pin_enable;
  logic             control_one_done;
  logic             reset_pin_done;
  logic             watchdog_clock_select;
  logic             watchdog_window_mode;
  logic             control_two_done;
  logic             spi_filter_enable;
  logic             flash_unlock;
  logic             flash_protection_disable;
  logic [7:0]       boot_semaphore;
  logic [7:0]       reset_status_register;
  logic [7:0]       rd_data;
  logic [7:0]       read_value;
  logic [14:0]      lpo_count;
  logic             lpo_tick;
  logic             warm_q;
  logic             cause_wd;
  logic             cause_pin;
  logic             next_warm;
  logic             pin_reset;
  logic             wr_go;
  logic             wr_control_one;
  logic             wr_control_two;
  logic             wr_unlock;
  logic             wr_sema;
  logic             wr_status;
  logic             wr_protect;
  logic             wd_timeout;
  logic             window_open;
  logic             wd_enabled;
  logic             window_violation;
  logic             service;
  sow_pkg::sow_seq_t sv_state;
  sow_pkg::sow_seq_t ul_state;

  // Writes landing in the warm reset cycle are dropped
  assign wr_go          = wr_strobe_in && !warm_q;
  assign wr_control_one = wr_go && (addr_in == sow_pkg::CONTROL_ONE_OFFSET);
  assign wr_control_two = wr_go && (addr_in == sow_pkg::CONTROL_TWO_OFFSET);
  assign wr_unlock      = wr_go && (addr_in == sow_pkg::UNLOCK_OFFSET);
  assign wr_sema        = wr_go && (addr_in == sow_pkg::SEMA_OFFSET);
  assign wr_status      = wr_go && (addr_in == sow_pkg::STATUS_OFFSET);
  assign wr_protect     = wr_go && (addr_in == sow_pkg::PROTECT_OFFSET);

  // Slow watchdog clock as an enable pulse
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lpo_count <= 15'h0000;
      lpo_tick  <= 1'b0;
    end else if (lpo_count == 15'(LPO_DIV - 1)) begin
      lpo_count <= 15'h0000;
      lpo_tick  <= 1'b1;
    end else begin
      lpo_count <= lpo_count + 15'h0001;
      lpo_tick  <= 1'b0;
    end
  end

  // Warm reset: one cycle, covers every reset except power-on
  assign pin_reset = reset_pin_enable && !reset_pin_n_in;
  assign next_warm = sys_reset_in || wd_timeout || window_violation || pin_reset;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      warm_q    <= 1'b0;
      cause_wd  <= 1'b0;
      cause_pin <= 1'b0;
    end else begin
      warm_q    <= next_warm;
      cause_wd  <= wd_timeout || window_violation;
      cause_pin <= pin_reset;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reset_status_register <= sow_pkg::STATUS_POR;
    end else if (warm_q) begin
      reset_status_register                      <= 8'h00;
      reset_status_register[sow_pkg::RS_PIN_BIT] <= cause_pin;
      reset_status_register[sow_pkg::RS_WD_BIT]  <= cause_wd;
    end
  end

  // First control register, write-once
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      watchdog_timeout_select <= sow_pkg::WD_SEL_RESET;
      debug_pin_enable        <= sow_pkg::DBG_RESET;
      control_one_done        <= 1'b0;
    end else if (warm_q) begin
      watchdog_timeout_select <= sow_pkg::WD_SEL_RESET;
      debug_pin_enable        <= sow_pkg::DBG_RESET;
      control_one_done        <= 1'b0;
    end else if (wr_control_one && !control_one_done) begin
      watchdog_timeout_select <= wr_data_in[sow_pkg::WD_SEL_LSB +: 2];
      debug_pin_enable        <= wr_data_in[sow_pkg::DBG_BIT];
      control_one_done        <= 1'b1;
    end
  end

  // Only power-on reset rearms the reset pin choice
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reset_pin_enable <= sow_pkg::RESET_PIN_POR;
      reset_pin_done   <= 1'b0;
    end else if (wr_control_one && !reset_pin_done) begin
      reset_pin_enable <= wr_data_in[sow_pkg::RESET_PIN_BIT];
      reset_pin_done   <= 1'b1;
    end
  end

  // Second control register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      watchdog_clock_select <= sow_pkg::CLKSEL_RESET;
      watchdog_window_mode  <= sow_pkg::WIN_RESET;
      control_two_done      <= 1'b0;
    end else if (warm_q) begin
      watchdog_clock_select <= sow_pkg::CLKSEL_RESET;
      watchdog_window_mode  <= sow_pkg::WIN_RESET;
      control_two_done      <= 1'b0;
    end else if (wr_control_two && !control_two_done) begin
      watchdog_clock_select <= wr_data_in[sow_pkg::CLKSEL_BIT];
      watchdog_window_mode  <= wr_data_in[sow_pkg::WIN_BIT];
      control_two_done      <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      spi_filter_enable <= sow_pkg::SPI_FILTER_RESET;
    end else if (warm_q) begin
      spi_filter_enable <= sow_pkg::SPI_FILTER_RESET;
    end else if (wr_control_two) begin
      spi_filter_enable <= wr_data_in[sow_pkg::SPI_FILTER_BIT];
    end
  end

  // Unlock key: any bus write other than another 0x55 to the unlock offset breaks a pending 0x55
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ul_state <= sow_pkg::SOW_SEQ_IDLE;
    end else if (warm_q) begin
      ul_state <= sow_pkg::SOW_SEQ_IDLE;
    end else if (wr_go) begin
      if (wr_unlock && (wr_data_in == sow_pkg::SEQ_FIRST)) begin
        ul_state <= sow_pkg::SOW_SEQ_ARMED;
      end else begin
        ul_state <= sow_pkg::SOW_SEQ_IDLE;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flash_unlock <= 1'b0;
    end else if (warm_q) begin
      flash_unlock <= 1'b0;
    end else if (wr_unlock) begin
      flash_unlock <= (ul_state == sow_pkg::SOW_SEQ_ARMED) &&
                      (wr_data_in == sow_pkg::SEQ_SECOND);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flash_protection_disable <= 1'b0;
    end else if (warm_q) begin
      flash_protection_disable <= 1'b0;
    end else if (wr_protect) begin
      // Clearing is always allowed, setting needs the key
      flash_protection_disable <= wr_data_in[sow_pkg::PROT_DISABLE_BIT] &&
                                  (flash_unlock || flash_protection_disable);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boot_semaphore <= sow_pkg::SEMA_POR;
    end else if (wr_sema) begin
      boot_semaphore <= wr_data_in;
    end
  end

  // Watchdog service through the status register
  assign wd_enabled       = (watchdog_timeout_select != sow_pkg::WD_SEL_OFF);
  assign window_violation = wr_status && watchdog_window_mode && wd_enabled &&
                            !window_open;
  assign service          = wr_status && !window_violation &&
                            (sv_state == sow_pkg::SOW_SEQ_ARMED) &&
                            (wr_data_in == sow_pkg::SEQ_SECOND);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sv_state <= sow_pkg::SOW_SEQ_IDLE;
    end else if (warm_q) begin
      sv_state <= sow_pkg::SOW_SEQ_IDLE;
    end else if (wr_status) begin
      unique case (sv_state)
        sow_pkg::SOW_SEQ_IDLE: begin
          if (wr_data_in == sow_pkg::SEQ_FIRST) begin
            sv_state <= sow_pkg::SOW_SEQ_ARMED;
          end
        end
        sow_pkg::SOW_SEQ_ARMED: begin
          if (wr_data_in != sow_pkg::SEQ_FIRST) begin
            sv_state <= sow_pkg::SOW_SEQ_IDLE;
          end
        end
        default: begin
          sv_state <= sow_pkg::SOW_SEQ_IDLE;
        end
      endcase
    end
  end

  sow_wd_counter u_counter (
    .clk_in            (clk_in),
    .reset_n_in        (reset_n_in),
    .restart_in        (warm_q || service),
    .tick_in           (watchdog_clock_select || lpo_tick),
    .timeout_select_in (watchdog_timeout_select),
    .clock_select_in   (watchdog_clock_select),
    .timeout_out       (wd_timeout),
    .window_open_out   (window_open)
  );

  // Register read, data in the following cycle only
  always_comb begin
    read_value = 8'h00;
    case (addr_in)
      sow_pkg::CONTROL_ONE_OFFSET: begin
        read_value[sow_pkg::WD_SEL_LSB +: 2] = watchdog_timeout_select;
        read_value[sow_pkg::DBG_BIT]         = debug_pin_enable;
        read_value[sow_pkg::RESET_PIN_BIT]   = reset_pin_enable;
      end
      sow_pkg::CONTROL_TWO_OFFSET: begin
        read_value[sow_pkg::CLKSEL_BIT]     = watchdog_clock_select;
        read_value[sow_pkg::WIN_BIT]        = watchdog_window_mode;
        read_value[sow_pkg::SPI_FILTER_BIT] = spi_filter_enable;
      end
      sow_pkg::UNLOCK_OFFSET: read_value[sow_pkg::UNLOCK_BIT] = flash_unlock;
      sow_pkg::SEMA_OFFSET:   read_value = boot_semaphore;
      sow_pkg::STATUS_OFFSET: read_value = reset_status_register;
      sow_pkg::PROTECT_OFFSET: read_value[sow_pkg::PROT_DISABLE_BIT] = flash_protection_disable;
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_strobe_in ? read_value : 8'h00;
    end
  end

  assign rd_data_out                  = rd_data;
  assign debug_pin_enable_out         = debug_pin_enable;
  assign reset_pin_enable_out         = reset_pin_enable;
  assign reset_pullup_enable_out      = reset_pin_enable;
  assign spi_filter_enable_out        = spi_filter_enable;
  assign flash_protection_disable_out = flash_protection_disable;
  assign system_reset_out             = warm_q;

  sequence s_unlock_key;
    wr_unlock && (wr_data_in == sow_pkg::SEQ_FIRST) ##1
    wr_unlock && (wr_data_in == sow_pkg::SEQ_SECOND);
  endsequence

  sequence s_wd_reset;
    warm_q ##1 reset_status_register[sow_pkg::RS_WD_BIT];
  endsequence

  chk_debug_pin_restore: assert property (
    @(posedge clk_in) disable iff (!reset_n_in) warm_q |=> debug_pin_enable_out)
    else $error("debug pin enable not restored by reset");

  chk_reset_pin_kept: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    warm_q && reset_pin_enable_out |=> reset_pin_enable_out)
    else $error("reset pin configuration lost on internal reset");

  chk_reset_pin_acts: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    reset_pullup_enable_out && !reset_pin_n_in |=> system_reset_out)
    else $error("low reset pin did not reset the device");

  chk_timeout_sel_once: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    control_one_done && !warm_q |=> $stable(watchdog_timeout_select))
    else $error("timeout select changed after first write");

  chk_control_two_once: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    control_two_done && !warm_q |=> $stable({watchdog_clock_select, watchdog_window_mode}))
    else $error("clock select or window mode changed after first write");

  chk_unlock_key_sets: assert property (
    @(posedge clk_in) disable iff (!reset_n_in) s_unlock_key |=> flash_unlock)
    else $error("unlock key did not set unlock bit");

  chk_unlock_other_clr: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    wr_unlock && !((ul_state == sow_pkg::SOW_SEQ_ARMED) &&
                   (wr_data_in == sow_pkg::SEQ_SECOND)) |=> !flash_unlock)
    else $error("stray unlock write did not clear unlock bit");

  chk_flash_protection_disable_blocked: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    !flash_unlock && !flash_protection_disable_out |=> !flash_protection_disable_out)
    else $error("protection disable set while locked");

  chk_semaphore_kept: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    warm_q && !wr_strobe_in |=> $stable(boot_semaphore))
    else $error("semaphore changed by warm reset");

  chk_wd_cause_flag: assert property (
    @(posedge clk_in) disable iff (!reset_n_in) wd_timeout |=> s_wd_reset)
    else $error("watchdog timeout did not reset with cause flag");

  chk_window_early: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    wr_status && watchdog_window_mode && wd_enabled && !window_open
    |=> system_reset_out ##1 reset_status_register[sow_pkg::RS_WD_BIT])
    else $error("early service write did not reset");
endmodule

/* File: design/sow_pkg.sv */
// Constants and types for the system option and watchdog block
package sow_pkg;
  // Bus clock and low-power watchdog clock
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned LPO_PERIOD_NS  = 1000000;
  localparam int unsigned LPO_DIV_CYCLES = LPO_PERIOD_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [2:0] CONTROL_ONE_OFFSET = 3'h0;
  localparam logic [2:0] CONTROL_TWO_OFFSET = 3'h1;
  localparam logic [2:0] UNLOCK_OFFSET      = 3'h2;
  localparam logic [2:0] SEMA_OFFSET        = 3'h3;
  localparam logic [2:0] STATUS_OFFSET      = 3'h4;
  localparam logic [2:0] PROTECT_OFFSET     = 3'h5;

  // Two-byte key for service and unlock sequences
  localparam logic [7:0] SEQ_FIRST  = 8'h55;
  localparam logic [7:0] SEQ_SECOND = 8'haa;

  // Field positions
  localparam int WD_SEL_LSB       = 6;
  localparam int DBG_BIT          = 1;
  localparam int RESET_PIN_BIT    = 0;
  localparam int CLKSEL_BIT       = 7;
  localparam int WIN_BIT          = 6;
  localparam int SPI_FILTER_BIT   = 2;
  localparam int UNLOCK_BIT       = 0;
  localparam int PROT_DISABLE_BIT = 7;
  localparam int RS_PIN_BIT       = 6;
  localparam int RS_WD_BIT        = 5;

  // Reset values, and the watchdog-off select code
  localparam logic [1:0] WD_SEL_RESET     = 2'h3;
  localparam logic [1:0] WD_SEL_OFF       = 2'h0;
  localparam logic       DBG_RESET        = 1'h1;
  localparam logic       RESET_PIN_POR    = 1'h0;
  localparam logic       CLKSEL_RESET     = 1'h0;
  localparam logic       WIN_RESET        = 1'h0;
  localparam logic       SPI_FILTER_RESET = 1'h1;
  localparam logic [7:0] STATUS_POR       = 8'h82;
  localparam logic [7:0] SEMA_POR         = 8'h00;

  // Last count before overflow, and first count of the service window
  localparam logic [17:0] WD_LPO_LAST_1 = 18'h0001f;
  localparam logic [17:0] WD_LPO_LAST_2 = 18'h000ff;
  localparam logic [17:0] WD_LPO_LAST_3 = 18'h003ff;
  localparam logic [17:0] WD_LPO_OPEN_1 = 18'h00018;
  localparam logic [17:0] WD_LPO_OPEN_2 = 18'h000c0;
  localparam logic [17:0] WD_LPO_OPEN_3 = 18'h00300;
  localparam logic [17:0] WD_BUS_LAST_1 = 18'h01fff;
  localparam logic [17:0] WD_BUS_LAST_2 = 18'h0ffff;
  localparam logic [17:0] WD_BUS_LAST_3 = 18'h3ffff;
  localparam logic [17:0] WD_BUS_OPEN_1 = 18'h01800;
  localparam logic [17:0] WD_BUS_OPEN_2 = 18'h0c000;
  localparam logic [17:0] WD_BUS_OPEN_3 = 18'h30000;

  typedef enum logic [1:0] {
    SOW_SEQ_IDLE  = 2'b01,
    SOW_SEQ_ARMED = 2'b10
  } sow_seq_t;
endpackage

/* File: design/sow_wd_counter.sv */
// Watchdog counter with overflow pulse and service window flag
`timescale 1ns/10ps
module sow_wd_counter (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       restart_in,
  input  wire logic       tick_in,
  input  wire logic [1:0] timeout_select_in,
  input  wire logic       clock_select_in,
  output logic            timeout_out,
  output logic            window_open_out
);
  logic [17:0] count;
  logic [17:0] last_count;
  logic [17:0] open_count;
  logic        enabled;
  logic        at_last;

  assign enabled = (timeout_select_in != sow_pkg::WD_SEL_OFF);
  assign at_last = enabled && tick_in && (count == last_count);

  always_comb begin
    last_count = sow_pkg::WD_BUS_LAST_3;
    open_count = 18'h00000;
    case ({clock_select_in, timeout_select_in})
      3'h1: begin
        last_count = sow_pkg::WD_LPO_LAST_1;
        open_count = sow_pkg::WD_LPO_OPEN_1;
      end
      3'h2: begin
        last_count = sow_pkg::WD_LPO_LAST_2;
        open_count = sow_pkg::WD_LPO_OPEN_2;
      end
      3'h3: begin
        last_count = sow_pkg::WD_LPO_LAST_3;
        open_count = sow_pkg::WD_LPO_OPEN_3;
      end
      3'h5: begin
        last_count = sow_pkg::WD_BUS_LAST_1;
        open_count = sow_pkg::WD_BUS_OPEN_1;
      end
      3'h6: begin
        last_count = sow_pkg::WD_BUS_LAST_2;
        open_count = sow_pkg::WD_BUS_OPEN_2;
      end
      3'h7: begin
        last_count = sow_pkg::WD_BUS_LAST_3;
        open_count = sow_pkg::WD_BUS_OPEN_3;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= 18'h00000;
    end else if (restart_in || !enabled || at_last) begin
      count <= 18'h00000;
    end else if (tick_in) begin
      count <= count + 18'h00001;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timeout_out <= 1'b0;
    end else begin
      timeout_out <= at_last && !restart_in;
    end
  end

  assign window_open_out = enabled && (count >= open_count);
endmodule

/* File: dv/test_sow_config.sv */
// Self-checking testbench for the system option and watchdog block
`timescale 1ns/10ps
module test_sow_config;
  localparam int LPO_DIV    = 4;
  localparam int TIME_LIMIT = 40000;

  logic       clk_in         = 1'b0;
  logic       reset_n_in     = 1'b0;
  logic       sys_reset_in   = 1'b0;
  logic       reset_pin_n_in = 1'b1;
  logic [2:0] addr_in        = 3'h0;
  logic [7:0] wr_data_in     = 8'h00;
  logic       wr_strobe_in   = 1'b0;
  logic       rd_strobe_in   = 1'b0;
  logic [7:0] rd_data_out;
  logic       debug_pin_enable_out;
  logic       reset_pin_enable_out;
  logic       reset_pullup_enable_out;
  logic       spi_filter_enable_out;
  logic       flash_protection_disable_out;
  logic       system_reset_out;
  int         miscompares = 0;
  int         num_checks  = 0;
  int         cycles      = 0;
  int         rst_seen    = 0;
  // Read flag, offset, data written or expected
  logic [11:0] ops [35] = '{
    12'h8c2, 12'h904, 12'ha00, 12'hb00, 12'hc82, 12'hd00,
    12'he00, 12'h6ff, 12'he00,
    12'h041, 12'h841, 12'h082, 12'h841,
    12'h180, 12'h1c4, 12'h984, 12'h180, 12'h980,
    12'h35a, 12'hb5a, 12'h580, 12'hd00,
    12'h255, 12'h35a, 12'h2aa, 12'ha00,
    12'h255, 12'h2aa, 12'ha01, 12'h580, 12'hd80,
    12'h200, 12'ha00, 12'h500, 12'hd00
  };

  sow_config #(.LPO_DIV(LPO_DIV)) dut_u (
    .clk_in                       (clk_in),
    .reset_n_in                   (reset_n_in),
    .sys_reset_in                 (sys_reset_in),
    .reset_pin_n_in               (reset_pin_n_in),
    .addr_in                      (addr_in),
    .wr_data_in                   (wr_data_in),
    .wr_strobe_in                 (wr_strobe_in),
    .rd_strobe_in                 (rd_strobe_in),
    .rd_data_out                  (rd_data_out),
    .debug_pin_enable_out         (debug_pin_enable_out),
    .reset_pin_enable_out         (reset_pin_enable_out),
    .reset_pullup_enable_out      (reset_pullup_enable_out),
    .spi_filter_enable_out        (spi_filter_enable_out),
    .flash_protection_disable_out (flash_protection_disable_out),
    .system_reset_out             (system_reset_out)
  );

  always #25 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (system_reset_out === 1'b1) begin
      rst_seen <= rst_seen + 1;
    end
    if (cycles == TIME_LIMIT) begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Inputs change by NBA at the edge; outputs read here are pre-edge values
  task automatic cyc();
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_strobe_in <= 1'b1;
    cyc();
    wr_strobe_in <= 1'b0;
    cyc();
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    addr_in <= a;
    rd_strobe_in <= 1'b1;
    cyc();
    rd_strobe_in <= 1'b0;
    cyc();
    chk($sformatf("read offset %0h", a), e, rd_data_out);
  endtask

  task automatic service();
    wr(sow_pkg::STATUS_OFFSET, sow_pkg::SEQ_FIRST);
    wr(sow_pkg::STATUS_OFFSET, sow_pkg::SEQ_SECOND);
  endtask

  // Cycles until a warm reset shows, bounded by hi
  task automatic wait_rst(input int lo, input int hi);
    int n;
    n = 0;
    while (system_reset_out !== 1'b1 && n <= hi) begin
      cyc();
      n++;
    end
    chk($sformatf("reset delay %0d in %0d to %0d", n, lo, hi), 8'h01, 8'(n >= lo && n <= hi));
    cyc();
    cyc();
  endtask

  task automatic quiet(input int n);
    int s;
    s = rst_seen;
    repeat (n) cyc();
    chk("no warm reset", 8'(s), 8'(rst_seen));
  endtask

  initial begin
    repeat (5) cyc();
    reset_n_in <= 1'b1;
    cyc();
    foreach (ops[i]) begin
      if (ops[i][11]) begin
        rd(ops[i][10:8], ops[i][7:0]);
      end else begin
        wr(ops[i][10:8], ops[i][7:0]);
      end
    end
    chk("debug pin", 8'h00, 8'(debug_pin_enable_out));
    chk("reset pin", 8'h01, 8'(reset_pin_enable_out));
    chk("pull-up", 8'h01, 8'(reset_pullup_enable_out));
    chk("spi filter", 8'h00, 8'(spi_filter_enable_out));
    chk("protection disable", 8'h00, 8'(flash_protection_disable_out));
    // Bus clock, 8192 count timeout; restart proven by surviving past it
    service();
    quiet(8000);
    service();
    wait_rst(8185, 8200);
    rd(3'h4, 8'h20);
    rd(3'h0, 8'hc3);
    rd(3'h3, 8'h5a);
    chk("debug pin", 8'h01, 8'(debug_pin_enable_out));
    chk("reset pin", 8'h01, 8'(reset_pin_enable_out));
    // Window mode: early status write resets, late service does not
    wr(3'h1, 8'hc0);
    wr(3'h0, 8'h43);
    wr(3'h4, 8'h55);
    wait_rst(0, 4);
    rd(3'h4, 8'h20);
    wr(3'h1, 8'hc0);
    wr(3'h0, 8'h43);
    wr(3'h1, 8'h00);
    rd(3'h1, 8'hc0);
    quiet(6200);
    service();
    quiet(100);
    sys_reset_in <= 1'b1;
    cyc();
    sys_reset_in <= 1'b0;
    wait_rst(0, 3);
    rd(3'h4, 8'h00);
    rd(3'h3, 8'h5a);
    reset_pin_n_in <= 1'b0;
    cyc();
    reset_pin_n_in <= 1'b1;
    wait_rst(0, 6);
    rd(3'h4, 8'h40);
    wr(3'h0, 8'h02);
    quiet(5000);
    reset_n_in <= 1'b0;
    cyc();
    reset_n_in <= 1'b1;
    cyc();
    rd(3'h3, 8'h00);
    chk("reset pin", 8'h00, 8'(reset_pin_enable_out));
    chk("pull-up", 8'h00, 8'(reset_pullup_enable_out));
    // Default select, slow clock: 1024 ticks of LPO_DIV cycles each
    wait_rst(4080, 4105);
    // Shortest slow-clock select: 32 ticks
    wr(3'h0, 8'h42);
    wait_rst(120, 128);
    end_of_test();
  end
endmodule
